// >>> hdl/gtf_irq_ctrl.sv
// sticky interrupt status with read clear, mask and level output
`timescale 1ns/1ns
module gtf_irq_ctrl
    import gtf_pkg::*;
#(
    parameter int W = gtf_pkg::IRQ_W
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // events and software access
    input  wire logic [W-1:0] evt_set,
    input  wire logic         stat_rd,
    input  wire logic         mask_we,
    input  wire logic [W-1:0] mask_wdata,
    // state out
    output logic      [W-1:0] status_q,
    output logic      [W-1:0] mask_q,
    output logic              irq
);
    // a read clears, but an event in the same cycle survives
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            status_q <= '0;
        else
            status_q <= (stat_rd ? '0 : status_q) | evt_set;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            mask_q <= W'(IRQ_MASK_RST);
        else if (mask_we)
            mask_q <= mask_wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(status_q & mask_q);
    end

    chk_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt_set != '0) |=> ((status_q & $past(evt_set)) == $past(evt_set)))
        else $error("event lost against clear");
    chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ##1 (irq == |($past(status_q) & $past(mask_q))))
        else $error("irq does not follow masked status");

endmodule

// >>> hdl/gtf_pkg.sv
// constants and types shared by the general timer and free counter block
package gtf_pkg;

    // ========================================================================
    // register bus
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFS_CFG       = 8'h8C;
    localparam logic [7:0]  OFS_CNT       = 8'h90;
    localparam logic [7:0]  OFS_FREE      = 8'h9C;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'hA0;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'hA4;

    // ========================================================================
    // field layout and reset values
    localparam int          CFG_EN_BIT    = 29;
    localparam int          LOAD_MSB      = 15;
    localparam int          CNT_W         = 16;
    localparam int          FREE_W        = 32;
    localparam logic [15:0] LOAD_RST      = 16'hFFFF;
    localparam logic [15:0] CNT_RST       = 16'hFFFF;
    localparam logic [31:0] FREE_RST      = 32'h00000000;
    localparam int          IRQ_W         = 2;
    localparam int          IRQ_TIMER_BIT = 0;
    localparam int          IRQ_WRAP_BIT  = 1;
    localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;

    // ========================================================================
    // timing
    localparam int          CLK_NS        = 20;
    localparam int          FREE_TICK_NS  = 40;
    localparam int          FREE_TICK_CYC = FREE_TICK_NS / CLK_NS;
    localparam int          TMR_TICK_NS   = 1000;
    localparam int          TMR_TICK_CYC  = (TMR_TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CLR_MAX_NS    = 160;
    localparam int          CLR_MAX_CYC   = CLR_MAX_NS / CLK_NS;

    // ========================================================================
    // timer states
    typedef enum logic {
        GTF_HALT,
        GTF_RUN
    } gtf_state_t;

endpackage

// >>> hdl/gtf_tick_gen.sv
// divider that gives a one-cycle tick every DIV clock cycles
`timescale 1ns/1ns
module gtf_tick_gen #(
    parameter int DIV = 2
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // tick out
    output logic      tick
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] div_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            div_reg <= '0;
            tick    <= 1'b0;
        end
        else
        begin
            tick    <= (div_reg == LAST);
            div_reg <= (div_reg == LAST) ? '0 : div_reg + CW'(1);
        end
    end

    chk_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick |=> !tick) else $error("tick longer than one cycle");

endmodule

// >>> hdl/gtf_timer_top.sv
// general down timer with periodic interrupt and wrapping tick counter
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns

// Functional notes
// - timer runs while config enable bit 29 is one, halts while zero
// - enable falling from one to zero forces the preload field to FFFFh
// - preload bits 15:0 are the start count; timer decrements from it once enabled
// - timer can raise host interrupts at the interval set by the preload
// - live 16-bit count readable in a read-only register resetting to FFFFh
// - free counter starts at zero after reset, adds one each 25MHz tick
// - free counter wraps from maximum to zero and keeps counting
// - free counter reaches zero within 160ns after reset; stale value tolerated meanwhile
// - free counter readable as read-only 32-bit register, reset 00000000h
module gtf_timer_top #(
    parameter int TICK_CYC = gtf_pkg::TMR_TICK_CYC
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    // register port
    input  wire logic [gtf_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [gtf_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [gtf_pkg::DATA_W-1:0] reg_rdata,
    // interrupt
    output logic                            irq
);
    import gtf_pkg::*;

    // ========================================================================
    // declarations
    logic                 en_reg;
    logic [CNT_W-1:0]     load_reg;
    logic [CNT_W-1:0]     cnt_reg;
    logic [CNT_W-1:0]     cnt_next;
    logic [FREE_W-1:0]    free_reg;
    gtf_state_t           state_reg;
    gtf_state_t           state_next;
    logic                 tmr_tick;
    logic                 free_tick;
    logic                 cfg_we;
    logic                 mask_we;
    logic                 stat_rd;
    logic                 expire;
    logic                 wrap;
    logic [IRQ_W-1:0]     evt_set;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;
    logic [DATA_W-1:0]    rd_next;
    logic [CNT_W:0]       gap_reg;
    logic                 gap_valid_reg;

    assign cfg_we  = reg_wr && (reg_addr == OFS_CFG);
    assign mask_we = reg_wr && (reg_addr == OFS_IRQ_MASK);
    assign stat_rd = reg_rd && (reg_addr == OFS_IRQ_STAT);

    // ========================================================================
    // time bases
    gtf_tick_gen #(
        .DIV (TICK_CYC)
    ) u_tmr_tick (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (tmr_tick)
    );

    gtf_tick_gen #(
        .DIV (FREE_TICK_CYC)
    ) u_free_tick (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (free_tick)
    );

    // ========================================================================
    // configuration register
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            en_reg <= 1'b0;
        else if (cfg_we)
            en_reg <= reg_wdata[CFG_EN_BIT];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            load_reg <= LOAD_RST;
        else if (cfg_we)
        begin
            if (en_reg && !reg_wdata[CFG_EN_BIT])
                load_reg <= LOAD_RST;
            else
                load_reg <= reg_wdata[LOAD_MSB:0];
        end
    end

    // ========================================================================
    // down timer
    assign expire = (state_reg == GTF_RUN) && en_reg && tmr_tick && (cnt_reg == '0);

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            GTF_HALT:
            begin
                if (en_reg)
                begin
                    state_next = GTF_RUN;
                    cnt_next   = load_reg;
                end
            end
            GTF_RUN:
            begin
                if (!en_reg)
                    state_next = GTF_HALT;
                else if (tmr_tick)
                begin
                    if (cnt_reg == '0)
                        cnt_next = load_reg;
                    else
                        cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            default:
            begin
                state_next = GTF_HALT;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state_reg <= GTF_HALT;
            cnt_reg   <= CNT_RST;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ========================================================================
    // check helper: timer ticks counted since the count was last loaded
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            gap_reg <= '0;
        else if ((state_reg == GTF_HALT) || expire)
            gap_reg <= '0;
        else if (tmr_tick && en_reg)
            gap_reg <= gap_reg + (CNT_W+1)'(1);
    end

    // a config write while counting spoils the interval comparison for that period
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            gap_valid_reg <= 1'b1;
        else if (cfg_we && en_reg)
            gap_valid_reg <= 1'b0;
        else if ((state_reg == GTF_HALT) || expire)
            gap_valid_reg <= 1'b1;
    end

    // ========================================================================
    // free counter
    assign wrap = free_tick && (free_reg == '1);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            free_reg <= FREE_RST;
        else if (free_tick)
            free_reg <= free_reg + FREE_W'(1);
    end

    // ========================================================================
    // interrupts
    assign evt_set[IRQ_TIMER_BIT] = expire;
    assign evt_set[IRQ_WRAP_BIT]  = wrap;

    gtf_irq_ctrl #(
        .W (IRQ_W)
    ) u_irq (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .evt_set    (evt_set),
        .stat_rd    (stat_rd),
        .mask_we    (mask_we),
        .mask_wdata (reg_wdata[IRQ_W-1:0]),
        .status_q   (irq_status),
        .mask_q     (irq_mask),
        .irq        (irq)
    );

    // ========================================================================
    // read data
    always_comb
    begin
        rd_next = '0;
        case (reg_addr)
            OFS_CFG:
            begin
                rd_next[CFG_EN_BIT]   = en_reg;
                rd_next[LOAD_MSB:0]   = load_reg;
            end
            OFS_CNT:
            begin
                rd_next[CNT_W-1:0]    = cnt_reg;
            end
            OFS_FREE:
            begin
                rd_next               = free_reg;
            end
            OFS_IRQ_STAT:
            begin
                rd_next[IRQ_W-1:0]    = irq_status;
            end
            OFS_IRQ_MASK:
            begin
                rd_next[IRQ_W-1:0]    = irq_mask;
            end
            default:
            begin
                rd_next = '0;
            end
        endcase
    end

    // data stand for the one cycle after the read strobe only
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rd_next;
        else
            reg_rdata <= '0;
    end

    // ========================================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    chk_run_follows_en: assert property (
        en_reg ##1 en_reg |-> state_reg == GTF_RUN)
        else $error("timer not running while enabled");
    chk_halt_holds: assert property (
        (state_reg == GTF_HALT) && !en_reg |=> $stable(cnt_reg))
        else $error("count moved while halted");
    chk_preload_force: assert property (
        $fell(en_reg) |-> load_reg == LOAD_RST)
        else $error("preload not forced on disable");
    chk_start_load: assert property (
        (state_reg == GTF_HALT) && en_reg |=> cnt_reg == $past(load_reg))
        else $error("start count not taken from preload");
    chk_tick_decrement: assert property (
        (state_reg == GTF_RUN) && en_reg && tmr_tick && (cnt_reg != '0)
        |=> cnt_reg == $past(cnt_reg) - 16'h0001)
        else $error("count did not decrement on tick");
    chk_no_tick_hold: assert property (
        (state_reg == GTF_RUN) && !tmr_tick |=> $stable(cnt_reg))
        else $error("count moved without tick");
    chk_expire_reload: assert property (
        expire |=> (cnt_reg == $past(load_reg)) && irq_status[IRQ_TIMER_BIT])
        else $error("no reload or flag at zero");
    chk_irq_interval: assert property (
        expire && irq_mask[IRQ_TIMER_BIT] && !mask_we |=> ##1 irq)
        else $error("unmasked expiry gave no interrupt");
    chk_free_step: assert property (
        free_tick |=> free_reg == $past(free_reg) + 32'h00000001)
        else $error("free counter missed a step");
    chk_free_idle: assert property (
        !free_tick |=> $stable(free_reg))
        else $error("free counter moved between ticks");
    chk_free_wrap: assert property (
        wrap |=> free_reg == '0 ##[1:2] free_reg == 32'h00000001)
        else $error("free counter did not wrap and continue");
    chk_free_clear: assert property (
        $rose(rst_b) |-> free_reg == FREE_RST)
        else $error("free counter not cleared after reset");
    chk_cnt_read: assert property (
        reg_rd && (reg_addr == OFS_CNT)
        |=> reg_rdata == {16'h0000, $past(cnt_reg)})
        else $error("count read mismatch");
    chk_free_read: assert property (
        reg_rd && (reg_addr == OFS_FREE) |=> reg_rdata == $past(free_reg))
        else $error("free counter read mismatch");
    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data present without a read");
    chk_cfg_read: assert property (
        reg_rd && (reg_addr == OFS_CFG)
        |=> reg_rdata == {2'h0, $past(en_reg), 13'h0000, $past(load_reg)})
        else $error("config read mismatch");
    chk_en_write: assert property (
        cfg_we |=> en_reg == $past(reg_wdata[CFG_EN_BIT]))
        else $error("enable bit not written");
    chk_preload_write: assert property (
        cfg_we && reg_wdata[CFG_EN_BIT]
        |=> load_reg == $past(reg_wdata[LOAD_MSB:0]))
        else $error("preload not written");
    chk_cnt_reset: assert property (
        $rose(rst_b) |-> cnt_reg == CNT_RST)
        else $error("count not reset");
    chk_flag_sticky: assert property (
        irq_status[IRQ_TIMER_BIT] && !stat_rd
        |=> irq_status[IRQ_TIMER_BIT])
        else $error("timer flag dropped without a read");
    chk_flag_clear: assert property (
        stat_rd && !evt_set[IRQ_TIMER_BIT]
        |=> !irq_status[IRQ_TIMER_BIT])
        else $error("timer flag not cleared by read");
    chk_irq_gap: assert property (
        expire && gap_valid_reg |-> gap_reg == {1'b0, load_reg})
        else $error("expiry interval differs from preload");
    chk_stat_read: assert property (
        reg_rd && (reg_addr == OFS_IRQ_STAT)
        |=> reg_rdata == {30'h00000000, $past(irq_status)})
        else $error("status read mismatch");
    chk_disable_halts: assert property (
        !en_reg |=> state_reg == GTF_HALT)
        else $error("timer not halted while disabled");

    cov_reload:     cover property (expire ##1 (cnt_reg == load_reg));
    cov_disable:    cover property ($fell(en_reg));
    cov_free_wrap:  cover property (wrap);
    cov_irq_rise:   cover property ($rose(irq));
    cov_halt_start: cover property ((state_reg == GTF_HALT) && en_reg);

endmodule

// >>> sim/testbench.sv
// self-checking testbench for the general timer and free counter block
`timescale 1ns/1ns
module testbench;
    import gtf_pkg::*;
    // ========================================================================
    // signals
    localparam int                TK = 2;
    logic                         sys_clk;
    logic                         rst_b;
    logic [ADDR_W-1:0]            reg_addr;
    logic [DATA_W-1:0]            reg_wdata;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [DATA_W-1:0]            reg_rdata;
    logic                         irq;
    int                           bad_count = 0;
    int                           samples_checked = 0;
    int                           cyc = 0;

    gtf_timer_top #(.TICK_CYC(TK)) gtf_timer_top_inst (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .irq       (irq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) cyc <= cyc + 1;

    // ========================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_irq(input logic lvl);
        int i;
        for (i = 0; i < 200; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (irq === lvl)
                return;
        end
        bad_count++;
        complete_run();
    endtask

    // ========================================================================
    // scenarios
    task automatic t_reset_values();
        logic [31:0] d;
        reg_read(OFS_CFG, d);
        check(d, 32'h0000FFFF);
        reg_read(OFS_CNT, d);
        check(d, 32'h0000FFFF);
        reg_read(OFS_FREE, d);
        check(32'(d < 32'h8), 32'h1);
        reg_read(OFS_IRQ_STAT, d);
        check(d, 32'h0);
        reg_read(OFS_IRQ_MASK, d);
        check(d, 32'h0);
        reg_read(8'h00, d);
        check(d, 32'h0);
    endtask

    task automatic t_free_count();
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        reg_read(OFS_FREE, a);
        reg_read(OFS_FREE, b);
        check(b - a, 32'h1);
        repeat (100) @(posedge sys_clk);
        reg_read(OFS_FREE, a);
        check(a - b, 32'h33);
        // a write to the read-only counter must not disturb it
        reg_write(OFS_FREE, 32'h0);
        reg_read(OFS_FREE, c);
        check(c - a, 32'h2);
    endtask

    task automatic t_config();
        logic [31:0] d;
        logic [31:0] x;
        reg_write(OFS_CFG, 32'hFFFF0005);
        reg_read(OFS_CNT, d);
        check(d, 32'h5);
        reg_read(OFS_CFG, d);
        check(d, 32'h20000005);
        reg_write(OFS_CFG, 32'h00001234);
        reg_read(OFS_CFG, d);
        check(d, 32'h0000FFFF);
        reg_read(OFS_CNT, x);
        repeat (20) @(posedge sys_clk);
        reg_read(OFS_CNT, d);
        check(d, x);
        reg_write(OFS_CNT, 32'h0);
        reg_read(OFS_CNT, d);
        check(d, x);
    endtask

    task automatic t_irq();
        logic [31:0] d;
        int          t1;
        reg_write(OFS_CFG, 32'h20000007);
        repeat (40) @(posedge sys_clk);
        #1 check({31'h0, irq}, 32'h0);
        reg_read(OFS_IRQ_STAT, d);
        check(d & 32'h1, 32'h1);
        reg_write(OFS_IRQ_MASK, 32'h1);
        reg_read(OFS_IRQ_MASK, d);
        check(d, 32'h1);
        reg_read(OFS_IRQ_STAT, d);
        wait_irq(1'b0);
        wait_irq(1'b1);
        t1 = cyc;
        reg_read(OFS_IRQ_STAT, d);
        check(d & 32'h1, 32'h1);
        wait_irq(1'b0);
        wait_irq(1'b1);
        check(32'(cyc - t1), 32'(8 * TK));
        reg_write(OFS_CFG, 32'h0);
        reg_read(OFS_IRQ_STAT, d);
        repeat (3) @(posedge sys_clk);
        #1 check({31'h0, irq}, 32'h0);
        reg_read(OFS_IRQ_STAT, d);
        check(d & 32'h1, 32'h0);
    endtask

    // ========================================================================
    // main sequence
    initial
    begin
        rst_b     = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        do_reset();
        t_reset_values();
        t_free_count();
        t_config();
        t_irq();
        do_reset();
        t_reset_values();
        complete_run();
    end
endmodule
